// >>> rtl/vic_irq_ctrl.sv
// Prioritised vectored interrupt controller for a small 32-bit core.
// Assumes the core reports handler entry and return as one-cycle pulses
// with the line number, and issues word-only register accesses.
//
// Contract
// - Each line has a priority of 0, 64, 128 or 192.
// - Smaller priority value means more urgent; 0 is most urgent.
// - Every input is caught both as a held level and a pulse; nmi_in has no edge sampler or latch and is passed on as a level.
// - One non-maskable input ignores enables and priorities.
// - Core state save and restore on exceptions needs no software.
// - A pending and enabled line is offered to the core by priority.
// - Disabled lines still go pending but are never offered.
// - Clear-enable: write 1 disables a line, read gives enables.
// - Set-pending: write 1 makes a line pending, read gives pending.
// - Set-pending on pending line changes nothing; disabled line goes pending.
// - Clear-pending leaves the active state untouched.
// - Eight priority words of four 8-bit fields, word access only.
// - Only field bits 7:6 stored; bits 5:0 read zero, ignore writes.
// - Line M priority sits in word M/4, byte lane M mod 4.
// - Pending on level while inactive, on rising edge, or by software.
// - Entry moves pending to active; return re-pends if level still high.
// - A pulse during the handler makes the line pending and active.
`timescale 1ns/10ps
`default_nettype none
`include "vic_cfg.svh"

module vic_irq_ctrl #(
  parameter int NUM_LINES = 32,
  parameter int ID_W = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Peripheral interrupt pins
  input wire logic [NUM_LINES-1:0] irq_lines,
  input wire logic nmi_in,
  // Register access port
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  // Core request
  output logic irq_req,
  output logic [ID_W-1:0] irq_id,
  output vic_pkg::vic_prio_t irq_prio,
  output logic nmi_req,
  // Core handler events
  input wire logic core_enter,
  input wire logic [ID_W-1:0] core_enter_id,
  input wire logic core_exit,
  input wire logic [ID_W-1:0] core_exit_id,
  // Line state view
  output logic [NUM_LINES-1:0] line_active
);

  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_req;
    logic [NUM_LINES-1:0] enable;
    vic_pkg::vic_prio_t [NUM_LINES-1:0] prio;
    logic ack;
    logic [31:0] rdata;
    logic [NUM_LINES-1:0] act;
  } vic_top_st_t;

  vic_top_st_t st_reg, st_next;

  // ************************************************
  // Per-line event vectors
  // ************************************************
  logic [NUM_LINES-1:0] pend_vec;
  logic [NUM_LINES-1:0] act_vec;
  logic [NUM_LINES-1:0] sw_set_vec;
  logic [NUM_LINES-1:0] sw_clr_vec;
  logic [NUM_LINES-1:0] enter_vec;
  logic [NUM_LINES-1:0] leave_vec;

  // ************************************************
  // Address decode
  // ************************************************
  logic hit_ena_set;
  logic hit_ena_clr;
  logic hit_pend_set;
  logic hit_pend_clr;
  logic hit_prio;
  logic [2:0] prio_word;
  logic wr_go;
  logic rd_go;

  always_comb begin
    hit_ena_set = (reg_addr == `VIC_ADDR_ENA_SET);
    hit_ena_clr = (reg_addr == `VIC_ADDR_ENA_CLR);
    hit_pend_set = (reg_addr == `VIC_ADDR_PEND_SET);
    hit_pend_clr = (reg_addr == `VIC_ADDR_PEND_CLR);
    // Word-aligned hits only, no byte lanes on this port
    hit_prio = (reg_addr >= `VIC_ADDR_PRIO_BASE) &&
               (reg_addr <= `VIC_ADDR_PRIO_LAST) &&
               (reg_addr[1:0] == 2'h0);
    prio_word = reg_addr[`VIC_PRIO_IDX_MSB:`VIC_PRIO_IDX_LSB];
    wr_go = reg_req && reg_wr;
    rd_go = reg_req && !reg_wr;
  end

  // ************************************************
  // Software pending strobes, one cycle each
  // ************************************************
  always_comb begin
    sw_set_vec = '0;
    sw_clr_vec = '0;
    if (wr_go && hit_pend_set) begin
      sw_set_vec = reg_wdata[NUM_LINES-1:0];
    end
    if (wr_go && hit_pend_clr) begin
      // Touches only pending; active stays in the line
      sw_clr_vec = reg_wdata[NUM_LINES-1:0];
    end
  end

  // ************************************************
  // Core handler events
  // ************************************************
  always_comb begin
    enter_vec = '0;
    leave_vec = '0;
    // Core does its own stacking; only entry and return are seen here
    if (core_enter) begin
      enter_vec[core_enter_id] = 1'b1;
    end
    if (core_exit) begin
      leave_vec[core_exit_id] = 1'b1;
    end
  end

  // ************************************************
  // Line state
  // ************************************************
  // Each pulse must be seen on at least one edge by the sampler.
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    vic_line u_line (
      .clock(clock),
      .sys_rst(sys_rst),
      .irq_in(irq_lines[g]),
      .sw_set(sw_set_vec[g]),
      .sw_clr(sw_clr_vec[g]),
      .enter(enter_vec[g]),
      .leave(leave_vec[g]),
      .pend(pend_vec[g]),
      .act(act_vec[g])
    );
  end

  // ************************************************
  // Priority selection
  // ************************************************
  vic_sel_if #(.N(NUM_LINES), .IW(ID_W)) sel_bus ();

  // Pending without enable never reaches the selector
  assign sel_bus.cand = pend_vec & st_reg.enable;
  assign sel_bus.prio = st_reg.prio;

  vic_arbiter #(.N(NUM_LINES), .IW(ID_W)) u_arb (
    .clock(clock),
    .sys_rst(sys_rst),
    .sel(sel_bus.arb)
  );

  // ************************************************
  // Read data
  // ************************************************
  logic [31:0] rd_word;
  logic [NUM_LINES-1:0] pend_rd;

  always_comb begin
    rd_word = `VIC_RST_WORD;
    pend_rd = pend_vec;
    if (hit_ena_set || hit_ena_clr) begin
      rd_word[NUM_LINES-1:0] = st_reg.enable;
    end else if (hit_pend_set || hit_pend_clr) begin
      rd_word[NUM_LINES-1:0] = pend_rd;
    end else if (hit_prio) begin
      for (int k = 0; k < `VIC_FIELDS_PER_WORD; k++) begin
        // Bits 5:0 of each field stay zero
        rd_word[k*`VIC_FIELD_W + `VIC_PRIO_FIELD_LSB +: 2] =
          st_reg.prio[{prio_word, 2'(k)}];
      end
    end
  end

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    st_next = st_reg;
    // Two stages before anything reads the pin
    st_next.nmi_s1 = nmi_in;
    st_next.nmi_s2 = st_reg.nmi_s1;
    // Not gated by any enable or priority
    st_next.nmi_req = st_reg.nmi_s2;
    st_next.act = act_vec;
    st_next.ack = reg_req;
    if (rd_go) begin
      st_next.rdata = rd_word;
    end
    if (wr_go && hit_ena_set) begin
      st_next.enable = st_reg.enable | reg_wdata[NUM_LINES-1:0];
    end
    if (wr_go && hit_ena_clr) begin
      st_next.enable = st_reg.enable & ~reg_wdata[NUM_LINES-1:0];
    end
    if (wr_go && hit_prio) begin
      for (int k = 0; k < `VIC_FIELDS_PER_WORD; k++) begin
        // Low six bits of each field dropped, so 255 stores 192
        st_next.prio[{prio_word, 2'(k)}] =
          reg_wdata[k*`VIC_FIELD_W + `VIC_PRIO_FIELD_LSB +: 2];
      end
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign reg_ack = st_reg.ack;
  assign reg_rdata = st_reg.rdata;
  assign irq_req = sel_bus.req;
  assign irq_id = sel_bus.id;
  assign irq_prio = sel_bus.best;
  assign nmi_req = st_reg.nmi_req;
  assign line_active = st_reg.act;

endmodule : vic_irq_ctrl

`default_nettype wire

// >>> rtl/vic_cfg.svh
// Address map, field layout and reset values of the interrupt controller.
// Assumes word-only register access on the core's private bus.
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH

`define VIC_ADDR_ENA_SET 32'he000e100
`define VIC_ADDR_ENA_CLR 32'he000e180
`define VIC_ADDR_PEND_SET 32'he000e200
`define VIC_ADDR_PEND_CLR 32'he000e280
`define VIC_ADDR_PRIO_BASE 32'he000e400
`define VIC_ADDR_PRIO_LAST 32'he000e41c
`define VIC_PRIO_IDX_MSB 4
`define VIC_PRIO_IDX_LSB 2
`define VIC_FIELD_W 8
`define VIC_FIELDS_PER_WORD 4
`define VIC_PRIO_FIELD_MSB 7
`define VIC_PRIO_FIELD_LSB 6
`define VIC_RST_WORD 32'h0000_0000
`define VIC_RST_PRIO 2'h0
`define VIC_PRIO_LOWEST 2'h3

`endif

// >>> rtl/vic_pkg.sv
// Shared types of the interrupt controller.
// Assumes the per-line state module and the top use these layouts.
package vic_pkg;

  // Implemented priority bits, field bits 7:6
  typedef logic [1:0] vic_prio_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pend;
    logic act;
  } vic_line_st_t;

endpackage : vic_pkg

// >>> rtl/vic_sel_if.sv
// Carrier between the controller top and its priority selector.
// Assumes a single clock domain; pure wiring, no clocking block.
`timescale 1ns/10ps
`default_nettype none

interface vic_sel_if #(
  parameter int N = 32,
  parameter int IW = 5
);
  logic [N-1:0] cand;
  vic_pkg::vic_prio_t [N-1:0] prio;
  logic req;
  logic [IW-1:0] id;
  vic_pkg::vic_prio_t best;

  modport ctrl (output cand, output prio, input req, input id, input best);
  modport arb (input cand, input prio, output req, output id, output best);
endinterface : vic_sel_if

`default_nettype wire

// >>> rtl/vic_line.sv
// Per-line pending/active state with input synchroniser and edge sampler.
// Assumes enter/leave/set/clear pulses come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none

module vic_line (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Peripheral request pin
  input wire logic irq_in,
  // Software and core events
  input wire logic sw_set,
  input wire logic sw_clr,
  input wire logic enter,
  input wire logic leave,
  // State
  output logic pend,
  output logic act
);
  vic_pkg::vic_line_st_t st_reg, st_next;
  logic rise;

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = irq_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    // Level and pulse both detected, no per-line style select
    rise = st_reg.sync2 & ~st_reg.prev;
    // ************************************************
    // Clears first, so that any set below wins
    // ************************************************
    if (enter) begin
      st_next.pend = 1'b0;
      st_next.act = 1'b1;
    end
    if (leave) begin
      st_next.act = 1'b0;
    end
    if (sw_clr) begin
      st_next.pend = 1'b0;
    end
    // ************************************************
    // Sets
    // ************************************************
    if (st_reg.sync2 && !st_reg.act && !enter) begin
      st_next.pend = 1'b1;
    end
    if (st_reg.sync2 && leave) begin
      st_next.pend = 1'b1;
    end
    if (rise) begin
      st_next.pend = 1'b1;
    end
    if (sw_set) begin
      st_next.pend = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pend = st_reg.pend;
  assign act = st_reg.act;
endmodule : vic_line

`default_nettype wire

// >>> rtl/vic_arbiter.sv
// Picks the most urgent enabled pending line, registered for the core.
// Assumes candidates are already gated by enable.
`timescale 1ns/10ps
`default_nettype none
`include "vic_cfg.svh"

module vic_arbiter #(
  parameter int N = 32,
  parameter int IW = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Selection carrier
  vic_sel_if.arb sel
);
  typedef struct packed {
    logic req;
    logic [IW-1:0] id;
    vic_pkg::vic_prio_t best;
  } vic_arb_st_t;

  vic_arb_st_t st_reg, st_next;

  always_comb begin
    st_next = '0;
    st_next.best = `VIC_PRIO_LOWEST;
    for (int i = 0; i < N; i++) begin
      // Strict compare keeps the lowest line on a tie
      if (sel.cand[i] && (!st_next.req || sel.prio[i] < st_next.best)) begin
        st_next.req = 1'b1;
        st_next.id = IW'(i);
        st_next.best = sel.prio[i];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sel.req = st_reg.req;
  assign sel.id = st_reg.id;
  assign sel.best = st_reg.best;
endmodule : vic_arbiter

`default_nettype wire

// >>> dv/vic_irq_ctrl_props.sv
// Assertion checker for the interrupt controller top.
// Assumes one clock domain; bound to every vic_irq_ctrl instance.
`timescale 1ns/10ps
`default_nettype none
module vic_irq_ctrl_props #(
  parameter int NUM_LINES = 32,
  parameter int ID_W = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  // Requests and handler events
  input wire logic nmi_in,
  input wire logic nmi_req,
  input wire logic irq_req,
  input wire logic [ID_W-1:0] irq_id,
  input wire vic_pkg::vic_prio_t irq_prio,
  input wire logic core_enter,
  input wire logic [ID_W-1:0] core_enter_id,
  input wire logic core_exit,
  input wire logic [ID_W-1:0] core_exit_id,
  input wire logic [NUM_LINES-1:0] line_active
);
  // Edges since reset, so $past never looks into reset
  logic [1:0] age_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ****************
  // Properties
  // ****************
  property p_ack; reg_req |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_noack; !reg_req |=> !reg_ack; endproperty
  a_noack: assert property (p_noack) else $error("stray ack");
  property p_hold; !(reg_req && !reg_wr) |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_mask;
    reg_req && !reg_wr && reg_addr[31:8] == 24'he000e4
      |=> (reg_rdata & 32'h3f3f3f3f) == 32'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("low bits set");
  property p_nmi; age_reg == 2'h3 |-> nmi_req == $past(nmi_in, 3); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi delay");
  property p_idle;
    age_reg != 2'h0 && !irq_req |-> irq_prio == 2'h3 && irq_id == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle value");
  property p_enter;
    core_enter && !core_exit |-> ##2 line_active[$past(core_enter_id, 2)];
  endproperty
  a_enter: assert property (p_enter) else $error("not active");
  property p_exit;
    core_exit && !core_enter |-> ##2 !line_active[$past(core_exit_id, 2)];
  endproperty
  a_exit: assert property (p_exit) else $error("still active");
endmodule : vic_irq_ctrl_props
bind vic_irq_ctrl vic_irq_ctrl_props #(.NUM_LINES(NUM_LINES), .ID_W(ID_W))
  u_vic_irq_ctrl_props (.clock(clock), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_ack(reg_ack), .reg_rdata(reg_rdata), .nmi_in(nmi_in),
  .nmi_req(nmi_req), .irq_req(irq_req), .irq_id(irq_id),
  .irq_prio(irq_prio), .core_enter(core_enter),
  .core_enter_id(core_enter_id), .core_exit(core_exit),
  .core_exit_id(core_exit_id), .line_active(line_active));
`default_nettype wire

// >>> dv/vic_core_model.sv
// Processor core model: takes the offered line and returns on command.
// Assumes bench commands are one-cycle pulses set at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module vic_core_model #(
  parameter int ID_W = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Controller request
  input wire logic irq_req,
  input wire logic [ID_W-1:0] irq_id,
  // Bench commands
  input wire logic take,
  input wire logic leave,
  // Handler events
  output logic core_enter,
  output logic [ID_W-1:0] core_enter_id,
  output logic core_exit,
  output logic [ID_W-1:0] core_exit_id
);
  // ****************
  // Handler entry and return
  // ****************
  logic [ID_W-1:0] cur;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_enter <= 1'b0;
      core_exit <= 1'b0;
      core_enter_id <= '0;
      core_exit_id <= '0;
      cur <= '0;
    end else begin
      // Only an offered line is taken; ids toggle when their command is absent
      core_enter <= take && irq_req;
      core_enter_id <= take ? irq_id : ~core_enter_id;
      core_exit <= leave;
      core_exit_id <= leave ? cur : ~core_exit_id;
      if (take && irq_req) begin
        cur <= irq_id;
      end
    end
  end
endmodule : vic_core_model
`default_nettype wire

// >>> dv/vic_irq_ctrl_tb_top.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model file and the bound checker are compiled too.
`timescale 1ns/10ps
`default_nettype none
module vic_irq_ctrl_tb_top;
  localparam logic [31:0] ES = 32'he000e100;
  localparam logic [31:0] EC = 32'he000e180;
  localparam logic [31:0] PS = 32'he000e200;
  localparam logic [31:0] PC = 32'he000e280;
  localparam logic [31:0] PR = 32'he000e400;
  logic clock, sys_rst, nmi_in, reg_req, reg_wr, reg_ack, irq_req, nmi_req;
  logic core_enter, core_exit, take, leave;
  logic [31:0] irq_lines, reg_addr, reg_wdata, reg_rdata, line_active;
  logic [4:0] irq_id, core_enter_id, core_exit_id;
  vic_pkg::vic_prio_t irq_prio;
  int err_total, cmp_count, cyc;
  vic_irq_ctrl u_vic_irq_ctrl (.clock(clock), .sys_rst(sys_rst),
    .irq_lines(irq_lines), .nmi_in(nmi_in), .reg_req(reg_req),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .irq_req(irq_req),
    .irq_id(irq_id), .irq_prio(irq_prio), .nmi_req(nmi_req),
    .core_enter(core_enter), .core_enter_id(core_enter_id),
    .core_exit(core_exit), .core_exit_id(core_exit_id),
    .line_active(line_active));
  vic_core_model u_vic_core_model (.clock(clock), .sys_rst(sys_rst),
    .irq_req(irq_req), .irq_id(irq_id), .take(take), .leave(leave),
    .core_enter(core_enter), .core_enter_id(core_enter_id),
    .core_exit(core_exit), .core_exit_id(core_exit_id));
  always #20 clock = ~clock;
  // ****************
  // Helpers
  // ****************
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] rq();
    return 32'({irq_req, irq_prio, irq_id});
  endfunction : rq
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  // One access, then a quiet cycle so requests never merge
  task automatic acc(input logic w, input logic [31:0] a, d);
    reg_req = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_req = 1'b0;
    chk(32'(reg_ack), 32'h1);
    @(negedge clock);
  endtask : acc
  task automatic rd(input logic [31:0] a, e);
    acc(1'b0, a, 32'h0);
    chk(reg_rdata, e);
  endtask : rd
  task automatic pulse(input int n);
    irq_lines[n] = 1'b1;
    @(negedge clock);
    irq_lines[n] = 1'b0;
  endtask : pulse
  task automatic cmd(input logic t);
    take = t;
    leave = !t;
    @(negedge clock);
    take = 1'b0;
    leave = 1'b0;
    idle(4);
  endtask : cmd
  // ****************
  // Scenarios
  // ****************
  task automatic s_regs;
    for (int i = 0; i < 4; i++) rd(ES + 32'(i) * 32'h80, 32'h0);
    for (int i = 0; i < 8; i++) rd(PR + 32'(i) * 32'h4, 32'h0);
    rd(32'he000e300, 32'h0);
    acc(1'b1, ES, 32'h5);
    acc(1'b1, ES, 32'h0);
    rd(ES, 32'h5);
    rd(EC, 32'h5);
    acc(1'b1, EC, 32'h1);
    rd(ES, 32'h4);
    for (int i = 0; i < 8; i++) acc(1'b1, PR + 32'(i) * 32'h4,
      32'h4182c3ff ^ (32'(i) << 29));
    acc(1'b1, PR + 32'h1, 32'hffffffff);
    for (int i = 0; i < 8; i++) rd(PR + 32'(i) * 32'h4,
      (32'h4182c3ff ^ (32'(i) << 29)) & 32'hc0c0c0c0);
  endtask : s_regs
  task automatic s_arb;
    acc(1'b1, PR, 32'h00c00000);
    acc(1'b1, PR + 32'h4, 32'h00004000);
    acc(1'b1, PR + 32'h8, 32'h00004000);
    acc(1'b1, PS, 32'h224);
    rd(PS, 32'h224);
    acc(1'b1, ES, 32'hffffffff);
    idle(2);
    chk(rq(), 32'ha5);
    acc(1'b1, PR + 32'h4, 32'h00008000);
    idle(2);
    chk(rq(), 32'ha9);
    acc(1'b1, EC, 32'h200);
    idle(2);
    chk(rq(), 32'hc5);
    acc(1'b1, PS, 32'h220);
    rd(PS, 32'h224);
    acc(1'b1, PC, 32'h20);
    idle(2);
    chk(rq(), 32'he2);
    acc(1'b1, PC, 32'h204);
    idle(2);
    chk(rq(), 32'h60);
  endtask : s_arb
  task automatic s_handler;
    pulse(4);
    idle(5);
    chk(rq(), 32'h84);
    cmd(1'b1);
    chk(line_active, 32'h10);
    rd(PS, 32'h0);
    pulse(4);
    idle(5);
    rd(PS, 32'h10);
    acc(1'b1, PC, 32'h10);
    chk(line_active, 32'h10);
    rd(PS, 32'h0);
    pulse(4);
    idle(5);
    cmd(1'b0);
    chk(line_active, 32'h0);
    rd(PS, 32'h10);
    irq_lines[4] = 1'b1;
    // Let the edge settle first, else it re-pends after entry
    idle(5);
    cmd(1'b1);
    rd(PS, 32'h0);
    cmd(1'b0);
    rd(PS, 32'h10);
    irq_lines[4] = 1'b0;
    cmd(1'b1);
    cmd(1'b0);
    rd(PS, 32'h0);
    chk(line_active, 32'h0);
  endtask : s_handler
  task automatic s_nmi;
    acc(1'b1, EC, 32'hffffffff);
    nmi_in = 1'b1;
    idle(4);
    chk(32'(nmi_req), 32'h1);
    nmi_in = 1'b0;
    idle(4);
    chk(32'(nmi_req), 32'h0);
  endtask : s_nmi
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {nmi_in, reg_req, reg_wr, take, leave} = 5'h0;
    {irq_lines, reg_addr, reg_wdata} = '0;
    {err_total, cmp_count} = '0;
    idle(5);
    sys_rst = 1'b0;
    s_regs();
    s_arb();
    s_handler();
    s_nmi();
    results();
  end
endmodule : vic_irq_ctrl_tb_top
`default_nettype wire
